// ---- core/fddm_core.sv ----
`timescale 1ns/1ps
module fddm_core
    import fddm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_coil,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [WORD_W-1:0] req_wdata,
    output logic req_busy,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [WORD_W-1:0] rsp_data,
    input wire logic [WORD_W-1:0] drive_status_word,
    input wire logic [WORD_W-1:0] output_frequency,
    input wire logic [WORD_W-1:0] feedback_value,
    input wire logic closed_loop,
    input wire logic drive_err_valid,
    input wire logic [WORD_W-1:0] drive_err_code,
    output logic param_req,
    output logic param_write,
    output logic [WORD_W-1:0] param_number,
    output logic [WORD_W-1:0] param_index,
    output logic [WORD_W-1:0] param_wdata,
    output logic param_store_nv,
    input wire logic param_ack,
    input wire logic param_error,
    input wire logic [WORD_W-1:0] param_err_code,
    input wire logic [WORD_W-1:0] param_rdata,
    output logic [WORD_W-1:0] drive_control_word,
    output logic [WORD_W-1:0] bus_speed_reference,
    output logic [1:0] preset_ref_sel,
    output logic dc_brake_req,
    output logic coast_req,
    output logic quick_stop_req,
    output logic freeze_req,
    output logic start_run,
    output logic fault_reset,
    output logic jog,
    output logic ramp2_sel,
    output logic data_valid,
    output logic relay1_on,
    output logic relay2_on,
    output logic [1:0] setup_sel,
    output logic reverse_dir
);

    logic [WORD_W-1:0] control_word_reg;
    logic [WORD_W-1:0] speed_ref_reg;
    logic [WORD_W-1:0] array_index_reg;
    logic [WORD_W-1:0] last_error_reg;
    logic store_target_reg;
    fddm_state_t state_reg;
    fddm_state_t state_next;

    // Decode of the current request
    logic take;
    logic is_param;
    logic rd_ok;
    logic wr_ok;
    logic [WORD_W-1:0] rd_word;
    logic [WORD_W-1:0] err_code;
    logic [WORD_W-1:0] actual_value;
    logic [3:0] bit_sel;
    logic [ADDR_W-1:0] reg_num;
    logic [WORD_W-1:0] status_masked;

    assign take = req_valid && (state_reg == FDDM_IDLE);
    assign status_masked = drive_status_word & STATUS_USED_MASK;
    assign actual_value = closed_loop ? feedback_value
                                      : output_frequency;
    assign reg_num = req_addr + ADDR_W'(1);

    always_comb
    begin
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        is_param = 1'b0;
        rd_word = '0;
        err_code = ERR_BAD_ADDRESS;
        bit_sel = req_addr[3:0];
        if (req_coil)
        begin
            // One bit per coil, returned in bit 0
            if (in_span(req_addr, COIL_CTL_FIRST, COIL_FIELD_LEN))
            begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
                rd_word = {15'h0000, control_word_reg[bit_sel]};
            end
            else if (in_span(req_addr, COIL_REF_FIRST, COIL_FIELD_LEN))
            begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
                rd_word = {15'h0000, speed_ref_reg[bit_sel]};
            end
            else if (in_span(req_addr, COIL_STS_FIRST, COIL_FIELD_LEN))
            begin
                rd_ok = 1'b1;
                rd_word = {15'h0000, status_masked[bit_sel]};
                err_code = ERR_NO_WRITE;
            end
            else if (in_span(req_addr, COIL_OUT_FIRST, COIL_FIELD_LEN))
            begin
                rd_ok = 1'b1;
                rd_word = {15'h0000, actual_value[bit_sel]};
                err_code = ERR_NO_WRITE;
            end
            else if (req_addr == item_addr(COIL_STORE))
            begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
                rd_word = {15'h0000, store_target_reg};
            end
        end
        else
        begin
            if (req_addr == item_addr(HREG_LAST_ERROR))
            begin
                rd_ok = 1'b1;
                rd_word = last_error_reg;
                err_code = ERR_NO_WRITE;
            end
            else if ((req_addr >= item_addr(HREG_RESERVED_FIRST) &&
                      req_addr <= item_addr(HREG_RESERVED_LAST)) ||
                     req_addr == item_addr(HREG_RESERVED_8))
            begin
                // Reserved words read zero and swallow writes
                rd_ok = 1'b1;
                wr_ok = 1'b1;
            end
            else if (req_addr == item_addr(HREG_ARRAY_INDEX))
            begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
                rd_word = array_index_reg;
            end
            else if (req_addr >= item_addr(HREG_PARAM_FIRST) &&
                     req_addr <= item_addr(HREG_PARAM_LAST))
            begin
                is_param = 1'b1;
            end
            else if (req_addr == item_addr(HREG_CONTROL_WORD))
            begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
                rd_word = control_word_reg;
            end
            else if (req_addr == item_addr(HREG_SPEED_REF))
            begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
                rd_word = speed_ref_reg;
            end
            else if (req_addr == item_addr(HREG_STATUS_WORD))
            begin
                rd_ok = 1'b1;
                rd_word = drive_status_word;
                err_code = ERR_NO_WRITE;
            end
            else if (req_addr == item_addr(HREG_ACTUAL_VALUE))
            begin
                rd_ok = 1'b1;
                rd_word = actual_value;
                err_code = ERR_NO_WRITE;
            end
        end
    end

    logic bad_access;
    assign bad_access = take && !is_param && (req_write ? !wr_ok : !rd_ok);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            FDDM_IDLE:
                if (take && is_param)
                    state_next = FDDM_PARAM;
            FDDM_PARAM:
                if (param_ack)
                    state_next = FDDM_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            state_reg <= FDDM_IDLE;
        else
            state_reg <= state_next;
    end

    // Coil and word writes share storage, so either view sees the other
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            control_word_reg <= CONTROL_WORD_RESET;
        else if (take && req_write && wr_ok && !is_param)
        begin
            if (req_coil && in_span(req_addr, COIL_CTL_FIRST, COIL_FIELD_LEN))
                control_word_reg[bit_sel] <= req_wdata[0];
            else if (!req_coil &&
                     req_addr == item_addr(HREG_CONTROL_WORD))
                control_word_reg <= req_wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            speed_ref_reg <= SPEED_REF_RESET;
        else if (take && req_write && wr_ok && !is_param)
        begin
            if (req_coil && in_span(req_addr, COIL_REF_FIRST, COIL_FIELD_LEN))
                speed_ref_reg[bit_sel] <= req_wdata[0];
            else if (!req_coil && req_addr == item_addr(HREG_SPEED_REF))
                speed_ref_reg <= req_wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            store_target_reg <= STORE_TARGET_RESET;
        else if (take && req_write && req_coil &&
                 req_addr == item_addr(COIL_STORE))
            store_target_reg <= req_wdata[0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            array_index_reg <= ARRAY_INDEX_RESET;
        else if (take && req_write && !req_coil &&
                 req_addr == item_addr(HREG_ARRAY_INDEX))
            array_index_reg <= req_wdata;
    end

    // Map errors take priority: the master's own request failed just now
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            last_error_reg <= LAST_ERROR_RESET;
        else if (bad_access)
            last_error_reg <= err_code;
        else if (state_reg == FDDM_PARAM && param_ack && param_error)
            last_error_reg <= param_err_code;
        else if (drive_err_valid)
            last_error_reg <= drive_err_code;
    end

    // Parameter hand-off; index and storage target travel with it
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            param_req <= 1'b0;
            param_write <= 1'b0;
            param_number <= '0;
            param_index <= '0;
            param_wdata <= '0;
            param_store_nv <= 1'b0;
        end
        else
        begin
            param_req <= take && is_param;
            if (take && is_param)
            begin
                param_write <= req_write;
                param_number <= WORD_W'(reg_num / PARAM_SCALE);
                param_index <= array_index_reg;
                param_wdata <= req_wdata;
                param_store_nv <= store_target_reg;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_data <= '0;
        end
        else if (take && !is_param)
        begin
            rsp_valid <= 1'b1;
            rsp_error <= bad_access;
            rsp_data <= (req_write || bad_access) ? '0 : rd_word;
        end
        else if (state_reg == FDDM_PARAM && param_ack)
        begin
            rsp_valid <= 1'b1;
            rsp_error <= param_error;
            rsp_data <= param_error ? '0 : param_rdata;
        end
        else
        begin
            rsp_valid <= 1'b0;
            rsp_error <= 1'b0;
            rsp_data <= '0;
        end
    end

    // Busy covers the cycle of the hand-off so a back-to-back request waits
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            req_busy <= 1'b0;
        else
            req_busy <= (state_next == FDDM_PARAM);
    end

    // Stop coils are active low on the bus; outputs here are active high
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            drive_control_word <= CONTROL_WORD_RESET;
            bus_speed_reference <= SPEED_REF_RESET;
            preset_ref_sel <= '0;
            dc_brake_req <= 1'b0;
            coast_req <= 1'b0;
            quick_stop_req <= 1'b0;
            freeze_req <= 1'b0;
            start_run <= 1'b0;
            fault_reset <= 1'b0;
            jog <= 1'b0;
            ramp2_sel <= 1'b0;
            data_valid <= 1'b0;
            relay1_on <= 1'b0;
            relay2_on <= 1'b0;
            setup_sel <= '0;
            reverse_dir <= 1'b0;
        end
        else
        begin
            drive_control_word <= control_word_reg;
            bus_speed_reference <= speed_ref_reg;
            preset_ref_sel <= {control_word_reg[CW_PRESET_MSB],
                               control_word_reg[CW_PRESET_LSB]};
            dc_brake_req <= !control_word_reg[CW_NO_DC_BRAKE];
            coast_req <= !control_word_reg[CW_NO_COAST];
            quick_stop_req <= !control_word_reg[CW_NO_QSTOP];
            freeze_req <= !control_word_reg[CW_NO_FREEZE];
            start_run <= control_word_reg[CW_START];
            fault_reset <= control_word_reg[CW_RESET];
            jog <= control_word_reg[CW_JOG];
            ramp2_sel <= control_word_reg[CW_RAMP2];
            data_valid <= control_word_reg[CW_DATA_VALID];
            relay1_on <= control_word_reg[CW_RELAY1];
            relay2_on <= control_word_reg[CW_RELAY2];
            setup_sel <= {control_word_reg[CW_SETUP_MSB],
                          control_word_reg[CW_SETUP_LSB]};
            reverse_dir <= control_word_reg[CW_REVERSE];
        end
    end

endmodule

// ---- core/fddm_pkg.sv ----
// Notes on behaviour
// - Each coil is one bit; each holding register is a 16-bit word.
// - Message addresses are zero-based: item N sits at address N minus one.
// - Holding numbers drop the leading 4; reference 40001 is address zero.
// - Coils 1-16 form the control word driving start, stops, relays, set-up.
// - Coils 17-32 carry the master's speed reference, -200% to +200%.
// - Coils 33-48 return the drive status word; unused bits read zero.
// - Coils 49-64 return output frequency open-loop, feedback closed-loop.
// - Coil 65 selects volatile-only or volatile plus nonvolatile storage.
// - Holding register 7 holds the last error code; 1-6 and 8 reserved.
// - Holding register 9 is the array index used on indexed parameters.
// - Parameter groups occupy 1000-register windows from 100 to 49999.
// - Control word is also the input-data holding register 500000.
// - Bus speed reference is the input-data holding register 50010.
// - Status word is the output-data holding register 50200.
// - Main actual value is the output-data holding register 50210.
// - A parameter's holding-register number is ten times its number.
package fddm_pkg;

    localparam int ADDR_W = 20;
    localparam int WORD_W = 16;

    // Item numbers as printed; addresses are derived by item_addr()
    localparam int COIL_CTL_FIRST = 1;
    localparam int COIL_REF_FIRST = 17;
    localparam int COIL_STS_FIRST = 33;
    localparam int COIL_OUT_FIRST = 49;
    localparam int COIL_STORE = 65;
    localparam int COIL_FIELD_LEN = 16;

    localparam int HREG_RESERVED_FIRST = 1;
    localparam int HREG_RESERVED_LAST = 6;
    localparam int HREG_LAST_ERROR = 7;
    localparam int HREG_RESERVED_8 = 8;
    localparam int HREG_ARRAY_INDEX = 9;
    localparam int HREG_PARAM_FIRST = 100;
    localparam int HREG_PARAM_LAST = 49999;
    localparam int HREG_CONTROL_WORD = 500000;
    localparam int HREG_SPEED_REF = 50010;
    localparam int HREG_STATUS_WORD = 50200;
    localparam int HREG_ACTUAL_VALUE = 50210;
    localparam int PARAM_SCALE = 10;

    // Control word bit positions (coil number minus one)
    localparam int CW_PRESET_LSB = 0;
    localparam int CW_PRESET_MSB = 1;
    localparam int CW_NO_DC_BRAKE = 2;
    localparam int CW_NO_COAST = 3;
    localparam int CW_NO_QSTOP = 4;
    localparam int CW_NO_FREEZE = 5;
    localparam int CW_START = 6;
    localparam int CW_RESET = 7;
    localparam int CW_JOG = 8;
    localparam int CW_RAMP2 = 9;
    localparam int CW_DATA_VALID = 10;
    localparam int CW_RELAY1 = 11;
    localparam int CW_RELAY2 = 12;
    localparam int CW_SETUP_LSB = 13;
    localparam int CW_SETUP_MSB = 14;
    localparam int CW_REVERSE = 15;

    // Status bits 37-39 and 45 are not used
    localparam logic [15:0] STATUS_USED_MASK = 16'hEF8F;

    localparam logic [15:0] CONTROL_WORD_RESET = 16'h0000;
    localparam logic [15:0] SPEED_REF_RESET = 16'h0000;
    localparam logic [15:0] ARRAY_INDEX_RESET = 16'h0000;
    localparam logic [15:0] LAST_ERROR_RESET = 16'h0000;
    localparam logic STORE_TARGET_RESET = 1'b0;

    // Error codes the map itself raises
    localparam logic [15:0] ERR_NO_WRITE = 16'h000B;
    localparam logic [15:0] ERR_BAD_ADDRESS = 16'h0040;

    typedef enum logic [0:0]
    {
        FDDM_IDLE = 1'b0,
        FDDM_PARAM = 1'b1
    } fddm_state_t;

    function automatic logic [ADDR_W-1:0] item_addr(input int item);
        item_addr = ADDR_W'(item - 1);
    endfunction

    function automatic logic in_span(input logic [ADDR_W-1:0] a,
                                     input int first_item,
                                     input int len);
        in_span = (a >= item_addr(first_item)) &&
                  (a < item_addr(first_item + len));
    endfunction

endpackage

// ---- tb/fddm_core_properties.sv ----
`timescale 1ns/1ps
module fddm_core_properties
    import fddm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_coil,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [WORD_W-1:0] req_wdata,
    input wire logic req_busy,
    input wire logic rsp_valid,
    input wire logic [WORD_W-1:0] rsp_data,
    input wire logic [WORD_W-1:0] drive_status_word,
    input wire logic [WORD_W-1:0] output_frequency,
    input wire logic [WORD_W-1:0] feedback_value,
    input wire logic closed_loop,
    input wire logic param_req,
    input wire logic [WORD_W-1:0] param_number,
    input wire logic param_ack,
    input wire logic [WORD_W-1:0] drive_control_word,
    input wire logic [WORD_W-1:0] bus_speed_reference,
    input wire logic start_run,
    input wire logic coast_req
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire tk = req_valid && !req_busy;
    wire hw = tk && !req_coil;
    wire hp = hw && req_addr >= 20'h00063 && req_addr <= 20'h0C34E;
    a_quick_answer: assert property (tk && !hp |=> rsp_valid)
        else $error("plain request not answered next cycle");
    a_param_issue: assert property (hp |=> param_req && req_busy &&
        param_number == 16'(($past(req_addr) + 20'h00001) / 20'h0000A))
        else $error("parameter request or number wrong");
    a_param_answer: assert property (param_ack && req_busy
        |=> rsp_valid && !req_busy)
        else $error("parameter acknowledge not answered");
    a_status_raw: assert property (hw && !req_write &&
        req_addr == 20'h0C417 |=> rsp_data == $past(drive_status_word))
        else $error("status word register read wrong");
    a_actual_pick: assert property (hw && !req_write &&
        req_addr == 20'h0C421 |=> rsp_data == ($past(closed_loop) ?
        $past(feedback_value) : $past(output_frequency)))
        else $error("actual value read wrong");
    a_speed_copy: assert property (hw && req_write &&
        req_addr == 20'h0C359 |=> ##1 bus_speed_reference == $past(req_wdata, 2))
        else $error("speed reference not copied");
    a_control_copy: assert property (hw && req_write &&
        req_addr == 20'h7A11F |=> ##1 drive_control_word == $past(req_wdata, 2))
        else $error("control word not copied");
    a_stop_decode: assert property (!$past(reset) |->
        coast_req == !drive_control_word[CW_NO_COAST] &&
        start_run == drive_control_word[CW_START])
        else $error("control word decode wrong");
endmodule

bind fddm_core fddm_core_properties u_props (.sys_clk, .reset, .req_valid,
    .req_coil, .req_write, .req_addr, .req_wdata, .req_busy, .rsp_valid,
    .rsp_data, .drive_status_word, .output_frequency, .feedback_value,
    .closed_loop, .param_req, .param_number, .param_ack, .drive_control_word,
    .bus_speed_reference, .start_run, .coast_req);

// ---- tb/fddm_core_test.sv ----
`timescale 1ns/1ps
module fddm_core_test;
    import fddm_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0, req_coil = 1'b0, req_write = 1'b0;
    logic closed_loop = 1'b0, drive_err_valid = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000, drive_status_word = 16'h0000;
    logic [15:0] output_frequency = 16'h0000, feedback_value = 16'h0000;
    logic [15:0] drive_err_code = 16'h0000;
    logic [3:0] lat = 4'h5;
    logic req_busy, rsp_valid, rsp_error, param_req, param_write;
    logic param_store_nv, param_ack, param_error, dc_brake_req, coast_req;
    logic quick_stop_req, freeze_req, start_run, fault_reset, jog;
    logic ramp2_sel, data_valid, relay1_on, relay2_on, reverse_dir;
    logic [1:0] preset_ref_sel, setup_sel;
    logic [15:0] rsp_data, param_number, param_index, param_wdata;
    logic [15:0] param_err_code, param_rdata, drive_control_word;
    logic [15:0] bus_speed_reference, q;
    logic e;
    int n_errors = 0;
    int samples_checked = 0;
    fddm_core DUT (.sys_clk, .reset, .req_valid, .req_coil, .req_write,
        .req_addr, .req_wdata, .req_busy, .rsp_valid, .rsp_error, .rsp_data,
        .drive_status_word, .output_frequency, .feedback_value, .closed_loop,
        .drive_err_valid, .drive_err_code, .param_req, .param_write,
        .param_number, .param_index, .param_wdata, .param_store_nv,
        .param_ack, .param_error, .param_err_code, .param_rdata,
        .drive_control_word, .bus_speed_reference, .preset_ref_sel,
        .dc_brake_req, .coast_req, .quick_stop_req, .freeze_req, .start_run,
        .fault_reset, .jog, .ramp2_sel, .data_valid, .relay1_on, .relay2_on,
        .setup_sel, .reverse_dir);
    fddm_drive_model u_drive (.sys_clk, .reset, .lat, .param_req,
        .param_write, .param_number, .param_wdata, .param_ack, .param_error,
        .param_err_code, .param_rdata);
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] got, x);
        samples_checked++;
        if (got !== x)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, x, got);
        end
    endtask
    task automatic acc(input logic c, w, input logic [19:0] a,
                       input logic [15:0] d);
        int i;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_coil <= c;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        for (i = 0; i < 40 && rsp_valid !== 1'b1; i++)
        begin
            #1;
            if (rsp_valid !== 1'b1)
                @(posedge sys_clk);
        end
        check("answer", {15'h0000, rsp_valid}, 16'h0001);
        if (i == 40)
            stop_test();
        q = rsp_data;
        e = rsp_error;
    endtask
    task automatic rd(input logic c, input logic [19:0] a,
                      input logic [15:0] x, input string nm);
        acc(c, 1'b0, a, 16'h0000);
        check(nm, q, x);
        check("no error", {15'h0000, e}, 16'h0000);
    endtask
    task automatic test_control();
        logic [15:0] p = 16'hA5C3;
        for (int k = 0; k < 16; k++)
            acc(1'b1, 1'b1, 20'(k), {15'h0000, p[k]});
        rd(1'b0, 20'h7A11F, p, "control word");
        @(posedge sys_clk);
        #1;
        check("decoded", {quick_stop_req, freeze_req, ramp2_sel,
            data_valid, relay1_on, relay2_on, start_run, coast_req,
            dc_brake_req, fault_reset, jog, reverse_dir, setup_sel,
            preset_ref_sel},
            {~p[4], ~p[5], p[9], p[10], p[11], p[12], p[6], ~p[3], ~p[2],
            p[7], p[8], p[15], p[14:13], p[1:0]});
        acc(1'b0, 1'b1, 20'h7A11F, 16'h5A3C);
        for (int k = 0; k < 16; k++)
            rd(1'b1, 20'(k), {15'h0000, ~p[k]}, "control coil");
        $display("test control done");
    endtask
    task automatic test_speed();
        acc(1'b0, 1'b1, 20'h0C359, 16'h8001);
        for (int k = 0; k < 16; k++)
            rd(1'b1, 20'(16 + k), {15'h0000, k == 0 || k == 15}, "ref");
        check("speed", bus_speed_reference, 16'h8001);
        $display("test speed done");
    endtask
    task automatic test_status();
        logic [15:0] v = 16'h4321;
        @(posedge sys_clk);
        drive_status_word <= 16'hFFFF;
        output_frequency <= 16'h1234;
        feedback_value <= v;
        for (int k = 0; k < 16; k++)
            rd(1'b1, 20'(32 + k), {15'h0000, STATUS_USED_MASK[k]}, "sts");
        rd(1'b0, 20'h0C417, 16'hFFFF, "status word");
        rd(1'b0, 20'h0C421, 16'h1234, "open loop");
        @(posedge sys_clk);
        closed_loop <= 1'b1;
        rd(1'b0, 20'h0C421, v, "closed loop");
        for (int k = 0; k < 16; k++)
            rd(1'b1, 20'(48 + k), {15'h0000, v[k]}, "actual coil");
        $display("test status done");
    endtask
    task automatic test_errors();
        acc(1'b1, 1'b1, 20'h00020, 16'h0001);
        check("ro coil", {15'h0000, e}, 16'h0001);
        rd(1'b0, 20'h00006, 16'h000B, "no write code");
        acc(1'b1, 1'b0, 20'h00041, 16'h0000);
        check("coil 66", {15'h0000, e}, 16'h0001);
        rd(1'b0, 20'h00006, 16'h0040, "bad addr code");
        acc(1'b0, 1'b0, 20'h00062, 16'h0000);
        check("reg 99", {15'h0000, e}, 16'h0001);
        acc(1'b0, 1'b1, 20'h00006, 16'h1111);
        check("reg 7 write", {15'h0000, e}, 16'h0001);
        acc(1'b0, 1'b1, 20'h00000, 16'hBEEF);
        check("reserved wr", {15'h0000, e}, 16'h0000);
        rd(1'b0, 20'h00000, 16'h0000, "reserved 1");
        rd(1'b0, 20'h00007, 16'h0000, "reserved 8");
        @(posedge sys_clk);
        drive_err_valid <= 1'b1;
        drive_err_code <= 16'h1234;
        @(posedge sys_clk);
        drive_err_valid <= 1'b0;
        rd(1'b0, 20'h00006, 16'h1234, "drive error");
        $display("test errors done");
    endtask
    task automatic test_params();
        acc(1'b0, 1'b1, 20'h00008, 16'h0003);
        rd(1'b0, 20'h00008, 16'h0003, "index");
        acc(1'b1, 1'b1, 20'h00040, 16'h0001);
        rd(1'b1, 20'h00040, 16'h0001, "store coil");
        acc(1'b0, 1'b1, 20'h003E7, 16'hCAFE);
        check("number", param_number, 16'h0064);
        check("index out", param_index, 16'h0003);
        check("nv", {14'h0000, param_store_nv, param_write}, 16'h0003);
        check("wdata", param_wdata, 16'hCAFE);
        lat <= 4'h0;
        rd(1'b0, 20'h003E7, 16'hCAFE, "param read");
        acc(1'b0, 1'b1, 20'h0C34E, 16'h0042);
        check("top number", param_number, 16'h1387);
        rd(1'b0, 20'h0C34E, 16'h0042, "top param");
        acc(1'b1, 1'b1, 20'h00040, 16'h0000);
        acc(1'b0, 1'b1, 20'h00063, 16'h0001);
        check("nv off", {15'h0000, param_store_nv}, 16'h0000);
        check("param err", {15'h0000, e}, 16'h0001);
        rd(1'b0, 20'h00006, 16'h0001, "param code");
        $display("test params done");
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        test_control();
        test_speed();
        test_status();
        test_errors();
        test_params();
        stop_test();
    end
endmodule

// ---- tb/fddm_drive_model.sv ----
`timescale 1ns/1ps
module fddm_drive_model
    import fddm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [3:0] lat,
    input wire logic param_req,
    input wire logic param_write,
    input wire logic [WORD_W-1:0] param_number,
    input wire logic [WORD_W-1:0] param_wdata,
    output logic param_ack,
    output logic param_error,
    output logic [WORD_W-1:0] param_err_code,
    output logic [WORD_W-1:0] param_rdata
);
    logic [WORD_W-1:0] mem_reg [16];
    logic [3:0] cnt_reg;
    logic busy_reg;
    // Parameter 10 plays a setting that refuses writes
    wire ro = param_number == 16'h000A;
    always_ff @(posedge sys_clk)
    begin
        param_ack <= 1'b0;
        param_error <= 1'b0;
        // Data is only meaningful with the acknowledge
        param_rdata <= ~param_rdata;
        if (reset)
        begin
            busy_reg <= 1'b0;
            param_rdata <= 16'h0000;
            param_err_code <= 16'h0000;
        end
        else if (param_req)
        begin
            busy_reg <= 1'b1;
            cnt_reg <= lat;
        end
        else if (busy_reg && cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
        else if (busy_reg)
        begin
            busy_reg <= 1'b0;
            param_ack <= 1'b1;
            param_error <= ro && param_write;
            param_err_code <= 16'h0001;
            param_rdata <= mem_reg[param_number[3:0]];
            if (param_write && !ro)
                mem_reg[param_number[3:0]] <= param_wdata;
        end
    end
endmodule
